// File: hdl/disp_port_pkg.sv
package disp_port_pkg;
    localparam int DIGITS = 8;
    localparam int GLYPHS = 16;
    localparam int ROWS = 7;
    localparam int ROW_W = 5;
    localparam logic [1:0] SEC_GLYPH_IDX = 2'h0;
    localparam logic [1:0] SEC_GLYPH_ROW = 2'h1;
    localparam logic [1:0] SEC_CONTROL = 2'h2;
    localparam logic [1:0] SEC_CHAR = 2'h3;
    localparam int CHAR_SRC_BIT = 7;
    localparam int FLASH_EN_BIT = 3;
    localparam logic [7:0] CHAR_RESET = 8'h20;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] GLYPH_IDX_RESET = 8'hFF;
    localparam logic [7:0] RD_PAD = 8'h00;
    localparam int FLASH_DIV = 28672;
    localparam int CLK_MHZ = 20;
    // Access pacing for the host end, in cycles
    localparam logic [3:0] HOST_SETUP = 4'h2;
    localparam logic [3:0] HOST_STROBE = 4'h3;
    localparam logic [3:0] HOST_IDLE = 4'h2;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] OP_READ = 2'h2;
    typedef enum logic [1:0] {
        SEL_NONE,
        SEL_READ,
        SEL_WRITE
    } access_t;
    function automatic logic [1:0] section_of(input logic [4:0] loc);
        return loc[4:3];
    endfunction
endpackage

// File: hdl/disp_port_if.sv
`timescale 1ns/10ps
interface disp_port_if;
    logic chip_sel_n;
    logic write_n;
    logic read_n;
    logic reset_n;
    logic blink_attr_select_n;
    logic [4:0] location_lines;
    logic [7:0] host_byte_out;
    logic host_byte_oe;
    logic [7:0] dev_byte_out;
    logic dev_byte_oe;
    logic [7:0] byte_lines;
    assign byte_lines = dev_byte_oe ? dev_byte_out : (host_byte_oe ? host_byte_out : 8'hFF);
    modport device (
        input chip_sel_n, write_n, read_n, reset_n, blink_attr_select_n, location_lines, byte_lines,
        output dev_byte_out, dev_byte_oe
    );
    modport host (
        output chip_sel_n, write_n, read_n, reset_n, blink_attr_select_n, location_lines, host_byte_out,
        output host_byte_oe,
        input byte_lines
    );
endinterface

// File: hdl/disp_device.sv
// What this block does
// - Access needs select low, one strobe low
// - Host holds address stable while selected
// - Low address lines pick digit 0..7
// - Bit 7 picks ASCII or glyph source
// - ASCII uses bits 0-6, glyph bits 0-3
// - Glyph index register 8 bits, low nibble
// - Host loads glyph index before row access
// - One glyph is seven write cycles
// - Low address picks row, bits 0-4 dots
// - Bit 0 rightmost column, bit 4 leftmost
// - Flash select alone picks attribute store
// - Data bit 0 sets or clears flash
// - Enabled flagged digits flash at refresh/28672
// - Host deasserts select between every cycle
// - Flash select, then lines 4:3 pick section
//
// The plain strobed port and the address map are this design's own decisions.
`timescale 1ns/10ps
module disp_device
    import disp_port_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    disp_port_if.device port,
    input wire logic [2:0] view_digit,
    input wire logic [2:0] view_row,
    output logic view_is_glyph,
    output logic [6:0] view_ascii,
    output logic [ROW_W-1:0] view_glyph_row,
    output logic view_lit,
    output logic [7:0] control_word
);
    ////////////////////////////////////////////////////////////////
    logic [7:0] char_q [DIGITS];
    logic [7:0] char_d [DIGITS];
    logic [ROW_W-1:0] glyph_q [GLYPHS*ROWS];
    logic [ROW_W-1:0] glyph_d [GLYPHS*ROWS];
    logic [DIGITS-1:0] flash_q, flash_d;
    logic [7:0] gidx_q, gidx_d;
    logic [7:0] ctrl_q, ctrl_d;
    logic [7:0] rdata_q, rdata_d;
    logic roe_q, roe_d;
    logic done_q, done_d;
    logic [14:0] div_q, div_d;
    logic phase_q, phase_d;
    logic half_tick;
    logic view_is_glyph_q, view_is_glyph_d;
    logic [6:0] view_ascii_q, view_ascii_d;
    logic [ROW_W-1:0] view_glyph_row_q, view_glyph_row_d;
    logic view_lit_q, view_lit_d;
    logic sel, wr, rd, port_rst;
    logic [2:0] low;
    logic [1:0] sec;
    access_t acc;

    function automatic int row_index(input logic [3:0] g, input logic [2:0] r);
        return int'(g) * ROWS + int'(r);
    endfunction

    ////////////////////////////////////////////////////////////////
    always_comb begin
        port_rst = !rst_n || !port.reset_n;
        sel = !port.chip_sel_n && port.reset_n;
        acc = SEL_NONE;
        if (sel && !port.write_n && port.read_n) begin
            acc = SEL_WRITE;
        end else if (sel && port.write_n && !port.read_n) begin
            acc = SEL_READ;
        end
        wr = (acc == SEL_WRITE) && !done_q;
        rd = (acc == SEL_READ);
        low = port.location_lines[2:0];
        sec = section_of(port.location_lines);
    end

    always_comb begin
        char_d = char_q;
        glyph_d = glyph_q;
        flash_d = flash_q;
        gidx_d = gidx_q;
        ctrl_d = ctrl_q;
        done_d = (acc != SEL_NONE);
        if (wr) begin
            if (!port.blink_attr_select_n) begin
                flash_d[low] = port.byte_lines[0];
            end else begin
                case (sec)
                    SEC_GLYPH_IDX: gidx_d = port.byte_lines;
                    SEC_GLYPH_ROW: begin
                        if (low < 3'(ROWS)) begin
                            glyph_d[row_index(gidx_q[3:0], low)] = port.byte_lines[ROW_W-1:0];
                        end
                    end
                    SEC_CONTROL: ctrl_d = port.byte_lines;
                    SEC_CHAR: char_d[low] = port.byte_lines;
                    default: ctrl_d = ctrl_q;
                endcase
            end
        end
    end

    always_comb begin
        rdata_d = RD_PAD;
        roe_d = rd;
        if (rd) begin
            if (!port.blink_attr_select_n) begin
                rdata_d = {7'h00, flash_q[low]};
            end else begin
                case (sec)
                    SEC_GLYPH_IDX: rdata_d = gidx_q;
                    SEC_GLYPH_ROW: begin
                        if (low < 3'(ROWS)) begin
                            rdata_d = {3'h0, glyph_q[row_index(gidx_q[3:0], low)]};
                        end
                    end
                    SEC_CONTROL: rdata_d = ctrl_q;
                    SEC_CHAR: rdata_d = char_q[low];
                    default: rdata_d = RD_PAD;
                endcase
            end
        end
    end

    always_comb begin
        div_d = div_q + 15'h0001;
        half_tick = 1'h0;
        if (div_q == 15'(FLASH_DIV / 2 - 1)) begin
            div_d = 15'h0000;
            half_tick = 1'h1;
        end
        phase_d = phase_q ^ half_tick;
    end

    ////////////////////////////////////////////////////////////////
    always_ff @(posedge clk) begin
        if (port_rst) begin
            for (int i = 0; i < DIGITS; i++) begin
                char_q[i] <= CHAR_RESET;
            end
            flash_q <= '0;
            ctrl_q <= CTRL_RESET;
            rdata_q <= RD_PAD;
            roe_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            char_q <= char_d;
            flash_q <= flash_d;
            ctrl_q <= ctrl_d;
            rdata_q <= rdata_d;
            roe_q <= roe_d;
            done_q <= done_d;
        end
    end

    // Flash divider restarts on either reset
    always_ff @(posedge clk) begin
        if (port_rst) begin
            div_q <= '0;
            phase_q <= 1'h0;
        end else begin
            div_q <= div_d;
            phase_q <= phase_d;
        end
    end

    // Glyph store and index survive the port reset
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            gidx_q <= GLYPH_IDX_RESET;
            for (int i = 0; i < GLYPHS*ROWS; i++) begin
                glyph_q[i] <= '0;
            end
        end else begin
            gidx_q <= gidx_d;
            glyph_q <= glyph_d;
        end
    end

    ////////////////////////////////////////////////////////////////
    assign port.dev_byte_out = rdata_q;
    assign port.dev_byte_oe = roe_q && rd;
    assign control_word = ctrl_q;
    assign view_is_glyph = view_is_glyph_q;
    assign view_ascii = view_ascii_q;
    assign view_glyph_row = view_glyph_row_q;
    assign view_lit = view_lit_q;

    always_comb begin
        view_is_glyph_d = char_q[view_digit][CHAR_SRC_BIT];
        view_ascii_d = char_q[view_digit][6:0];
        view_glyph_row_d = '0;
        if (view_row < 3'(ROWS)) begin
            // Bit 4 is the leftmost column
            view_glyph_row_d = glyph_q[row_index(char_q[view_digit][3:0], view_row)];
        end
        view_lit_d = !(ctrl_q[FLASH_EN_BIT] && flash_q[view_digit] && phase_q);
    end

    // View outputs lag the selectors by one cycle
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            view_is_glyph_q <= 1'h0;
            view_ascii_q <= 7'h00;
            view_glyph_row_q <= '0;
            view_lit_q <= 1'h1;
        end else begin
            view_is_glyph_q <= view_is_glyph_d;
            view_ascii_q <= view_ascii_d;
            view_glyph_row_q <= view_glyph_row_d;
            view_lit_q <= view_lit_d;
        end
    end
endmodule // disp_device

// File: hdl/disp_host.sv
`timescale 1ns/10ps
module disp_host
    import disp_port_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    disp_port_if.host port,
    input wire logic [1:0] op,
    input wire logic op_valid,
    input wire logic flash_sel,
    input wire logic [4:0] loc,
    input wire logic [7:0] wdata,
    input wire logic dev_reset,
    output logic op_ready,
    output logic [7:0] rdata,
    output logic rdata_valid
);
    typedef enum {IDLE, SETUP, STROBE, GAP} hstate_t;
    hstate_t st_q, st_d;
    logic [3:0] cnt_q, cnt_d;
    logic is_wr_q, is_wr_d;
    logic attr_q, attr_d;
    logic [4:0] loc_q, loc_d;
    logic [7:0] wd_q, wd_d;
    logic [7:0] rd_q, rd_d;
    logic rv_q, rv_d;

    ////////////////////////////////////////////////////////////////
    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q + 4'h1;
        is_wr_d = is_wr_q;
        attr_d = attr_q;
        loc_d = loc_q;
        wd_d = wd_q;
        rd_d = rd_q;
        rv_d = 1'b0;
        case (st_q)
            IDLE: begin
                cnt_d = '0;
                if (op_valid && (op == OP_WRITE || op == OP_READ)) begin
                    st_d = SETUP;
                    is_wr_d = (op == OP_WRITE);
                    attr_d = flash_sel;
                    loc_d = loc;
                    wd_d = wdata;
                end
            end
            SETUP: if (cnt_q == HOST_SETUP - 4'h1) begin
                st_d = STROBE;
                cnt_d = '0;
            end
            STROBE: if (cnt_q == HOST_STROBE - 4'h1) begin
                if (!is_wr_q) begin
                    rd_d = port.byte_lines;
                    rv_d = 1'b1;
                end
                st_d = GAP;
                cnt_d = '0;
            end
            GAP: if (cnt_q == HOST_IDLE - 4'h1) begin
                st_d = IDLE;
            end
            default: st_d = IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_q <= IDLE;
            cnt_q <= '0;
            is_wr_q <= 1'b0;
            attr_q <= 1'b0;
            loc_q <= '0;
            wd_q <= '0;
            rd_q <= '0;
            rv_q <= 1'b0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            is_wr_q <= is_wr_d;
            attr_q <= attr_d;
            loc_q <= loc_d;
            wd_q <= wd_d;
            rd_q <= rd_d;
            rv_q <= rv_d;
        end
    end

    ////////////////////////////////////////////////////////////////
    assign op_ready = (st_q == IDLE);
    assign rdata = rd_q;
    assign rdata_valid = rv_q;
    assign port.reset_n = !dev_reset;
    assign port.chip_sel_n = !(st_q == SETUP || st_q == STROBE);
    assign port.write_n = !(st_q == STROBE && is_wr_q);
    assign port.read_n = !(st_q == STROBE && !is_wr_q);
    // Flash request is active high here, the pin active low
    assign port.blink_attr_select_n = !attr_q;
    assign port.location_lines = loc_q;
    assign port.host_byte_out = wd_q;
    assign port.host_byte_oe = (st_q == SETUP || st_q == STROBE) && is_wr_q;
endmodule // disp_host

// File: verification/disp_port_chk.sv
`timescale 1ns/10ps
module disp_port_chk (
    input logic clk,
    input logic rst_n,
    input logic chip_sel_n,
    input logic write_n,
    input logic read_n,
    input logic blink_attr_select_n,
    input logic [4:0] location_lines,
    input logic [7:0] host_byte_out,
    input logic host_byte_oe,
    input logic dev_byte_oe
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////
    strobe_excl_a: assert property (!(!write_n && !read_n))
        else $error("both strobes low");
    strobe_sel_a: assert property ((!write_n || !read_n) |-> !chip_sel_n)
        else $error("strobe without select");
    addr_hold_a: assert property (!chip_sel_n && $past(!chip_sel_n) |->
        $stable(location_lines) && $stable(blink_attr_select_n)) else $error("address moved while selected");
    sel_gap_a: assert property ($rose(chip_sel_n) |-> ##1 chip_sel_n)
        else $error("select gap too short");
    dev_drive_a: assert property (dev_byte_oe |-> $past(!read_n && !chip_sel_n))
        else $error("device drives outside read");
    no_fight_a: assert property (!(dev_byte_oe && host_byte_oe))
        else $error("bus driven by both ends");
    host_data_a: assert property (!write_n |-> host_byte_oe && $stable(host_byte_out))
        else $error("write data not held");
    read_drive_a: assert property ($fell(read_n) |=> dev_byte_oe)
        else $error("read not answered");
endmodule // disp_port_chk

// File: verification/alnum_display_host_memory_port_tb.sv
`timescale 1ns/10ps
module alnum_display_host_memory_port_tb
    import disp_port_pkg::*;
;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [1:0] op = 2'h0;
    logic op_valid = 1'b0;
    logic flash_sel = 1'b0;
    logic [4:0] loc = 5'h00;
    logic [7:0] wdata = 8'h00;
    logic dev_reset = 1'b0;
    logic [2:0] view_digit = 3'h0;
    logic [2:0] view_row = 3'h0;
    logic op_ready, rdata_valid, view_is_glyph, view_lit;
    logic [7:0] rdata, control_word, r;
    logic [6:0] view_ascii;
    logic [4:0] view_glyph_row;
    int bad_count = 0;
    int n_tests = 0;
    int k;
    typedef struct {logic f; logic [4:0] a; logic [7:0] w; logic [7:0] e;} row_t;
    row_t rows [8] = '{'{1'b0, 5'h18, 8'h41, 8'h41}, '{1'b0, 5'h1F, 8'h83, 8'h83},
        '{1'b0, 5'h00, 8'h03, 8'h03}, '{1'b0, 5'h08, 8'hF1, 8'h11}, '{1'b0, 5'h0E, 8'h1F, 8'h1F},
        '{1'b1, 5'h1A, 8'hFF, 8'h01}, '{1'b1, 5'h05, 8'hFE, 8'h00}, '{1'b0, 5'h10, 8'h08, 8'h08}};
    ////////////////////////////////////////////////////////////////
    disp_port_if pif();
    disp_device i_disp_device(.clk, .rst_n, .port(pif), .view_digit, .view_row, .view_is_glyph,
        .view_ascii, .view_glyph_row, .view_lit, .control_word);
    disp_host i_disp_host(.clk, .rst_n, .port(pif), .op, .op_valid, .flash_sel, .loc, .wdata,
        .dev_reset, .op_ready, .rdata, .rdata_valid);
    disp_port_chk i_disp_port_chk(.clk, .rst_n, .chip_sel_n(pif.chip_sel_n), .write_n(pif.write_n),
        .read_n(pif.read_n), .blink_attr_select_n(pif.blink_attr_select_n),
        .location_lines(pif.location_lines), .host_byte_out(pif.host_byte_out),
        .host_byte_oe(pif.host_byte_oe), .dev_byte_oe(pif.dev_byte_oe));
    ////////////////////////////////////////////////////////////////
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic give_up(input int n);
        if (n >= 60) begin
            bad_count++;
            $display("CHECK FAILED at %0t: handshake timed out", $time);
            tally_and_finish();
        end
    endtask
    // One host operation; read result lands in r
    task automatic access(input logic [1:0] o, input logic f, input logic [4:0] a, input logic [7:0] w);
        int n;
        @(posedge clk);
        op <= o;
        flash_sel <= f;
        loc <= a;
        wdata <= w;
        op_valid <= 1'b1;
        n = 0;
        do begin @(negedge clk); n++; end while (op_ready !== 1'b1 && n < 60);
        give_up(n);
        @(posedge clk);
        op_valid <= 1'b0;
        if (o == OP_READ) begin
            n = 0;
            do begin @(negedge clk); n++; end while (rdata_valid !== 1'b1 && n < 60);
            give_up(n);
            r = rdata;
        end
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        forever #25 clk = ~clk;
    end
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        access(OP_READ, 1'b0, 5'h1B, 8'h00);
        check(r, CHAR_RESET);
        foreach (rows[i]) access(OP_WRITE, rows[i].f, rows[i].a, rows[i].w);
        foreach (rows[i]) begin
            access(OP_READ, rows[i].f, rows[i].a, 8'h00);
            check(r, rows[i].e);
        end
        check(control_word, 8'h08);
        @(posedge clk);
        view_digit <= 3'h7;
        view_row <= 3'h0;
        repeat (2) @(negedge clk);
        check({view_is_glyph, 2'h0, view_glyph_row}, 8'h91);
        @(posedge clk);
        view_digit <= 3'h0;
        repeat (2) @(negedge clk);
        check({view_is_glyph, view_ascii}, 8'h41);
        @(posedge clk);
        view_digit <= 3'h2;
        k = 0;
        do begin @(negedge clk); k++; end while (view_lit !== 1'b0 && k < 15000);
        check({7'h00, view_lit}, 8'h00);
        // Device reset clears characters and flash, keeps glyph slot
        @(posedge clk);
        dev_reset <= 1'b1;
        repeat (3) @(posedge clk);
        dev_reset <= 1'b0;
        repeat (4) @(posedge clk);
        access(OP_READ, 1'b0, 5'h18, 8'h00);
        check(r, CHAR_RESET);
        access(OP_READ, 1'b0, 5'h00, 8'h00);
        check(r, 8'h03);
        access(OP_READ, 1'b1, 5'h02, 8'h00);
        check(r, 8'h00);
        check(control_word, CTRL_RESET);
        // Upper index bits unused; row 7 does not exist
        access(OP_WRITE, 1'b0, 5'h00, 8'hF3);
        access(OP_READ, 1'b0, 5'h08, 8'h00);
        check(r, 8'h11);
        access(OP_WRITE, 1'b0, 5'h0F, 8'h1F);
        access(OP_READ, 1'b0, 5'h0F, 8'h00);
        check(r, RD_PAD);
        tally_and_finish();
    end
endmodule // alnum_display_host_memory_port_tb
